// [rtl/cbdsu_pkg.sv]
// Package of constants and types for the conditional branch delay slot unit
// How it works
// [RULE_01] Target is delay-slot address plus sign-extended offset shifted left two.
// [RULE_02] Taken branch redirects the PC only after the delay slot executes.
// [RULE_03] Negative tests are true exactly when the source sign bit is one.
// [RULE_04] Unequal tests are true exactly when both full source values differ.
// [RULE_05] Linking forms write register 31 whether or not the branch is taken.
// [RULE_06] Return address is the branch address plus eight.
// [RULE_07] Likely forms squash the delay-slot instruction when not taken.
// [RULE_08] Evaluate at the branch, apply redirect or squash in the next slot.
// [RULE_09] Software must not test register 31 in a linking form.
// [RULE_10] A slot exception restarts at the branch; evaluation is repeatable.
// [RULE_11] Software must not put branches, jumps, returns or wait in a slot.
// [RULE_12] Non-likely forms always execute the delay slot normally.
package cbdsu_pkg;
	localparam int          CBDSU_XLEN       = 32;
	localparam int          CBDSU_IMM_W      = 16;
	localparam int          CBDSU_IMM_SHIFT  = 2;
	localparam int          CBDSU_OFS_W      = 18;
	localparam logic [31:0] CBDSU_SLOT_STEP  = 32'h0000_0004;
	localparam logic [31:0] CBDSU_LINK_STEP  = 32'h0000_0008;
	localparam logic [4:0]  CBDSU_LINK_REG   = 5'h1F;
	localparam logic [31:0] CBDSU_PC_RST     = 32'h0000_0000;

	typedef enum logic [2:0] {
		CBDSU_OP_NONE                          = 3'h0,
		CBDSU_OP_BRANCH_IF_NEGATIVE            = 3'h1,
		CBDSU_OP_BRANCH_IF_NEGATIVE_LINK       = 3'h2,
		CBDSU_OP_BRANCH_IF_NEGATIVE_LINK_LIKELY = 3'h3,
		CBDSU_OP_BRANCH_IF_NEGATIVE_LIKELY     = 3'h4,
		CBDSU_OP_BRANCH_IF_UNEQUAL             = 3'h5,
		CBDSU_OP_BRANCH_IF_UNEQUAL_LIKELY      = 3'h6
	} cbdsu_op_t;

	// Gray path: idle -> slot pending -> idle
	typedef enum logic [0:0] {
		CBDSU_ST_IDLE = 1'b0,
		CBDSU_ST_SLOT = 1'b1
	} cbdsu_state_t;
endpackage

// [rtl/cbdsu_eval.sv]
// Combinational branch evaluator: condition, target and link address
`timescale 1ns/1ps
module cbdsu_eval (
	input  wire logic [2:0]  op_in,
	input  wire logic [31:0] branch_pc_in,
	input  wire logic [15:0] offset_in,
	input  wire logic [31:0] first_source_reg_in,
	input  wire logic [31:0] second_source_reg_in,
	output logic             is_branch_out,
	output logic             cond_out,
	output logic             likely_out,
	output logic             link_out,
	output logic [31:0]      target_out,
	output logic [31:0]      link_addr_out
);
	function automatic logic [31:0] cbdsu_sext_ofs(input logic [15:0] imm);
		logic [17:0] ofs;
		ofs = {imm, 2'h0};
		return {{14{ofs[17]}}, ofs};
	endfunction

	cbdsu_pkg::cbdsu_op_t op;
	logic                 neg;
	logic                 unequal;

	assign op      = cbdsu_pkg::cbdsu_op_t'(op_in);
	assign neg     = first_source_reg_in[31]; // [RULE_03]
	assign unequal = first_source_reg_in != second_source_reg_in; // [RULE_04]

	always_comb begin
		is_branch_out = 1'b1;
		cond_out      = 1'b0;
		likely_out    = 1'b0;
		link_out      = 1'b0;
		unique case (op)
		cbdsu_pkg::CBDSU_OP_BRANCH_IF_NEGATIVE: begin
			cond_out = neg;
		end
		cbdsu_pkg::CBDSU_OP_BRANCH_IF_NEGATIVE_LINK: begin
			cond_out = neg;
			link_out = 1'b1;
		end
		cbdsu_pkg::CBDSU_OP_BRANCH_IF_NEGATIVE_LINK_LIKELY: begin
			cond_out   = neg;
			link_out   = 1'b1;
			likely_out = 1'b1;
		end
		cbdsu_pkg::CBDSU_OP_BRANCH_IF_NEGATIVE_LIKELY: begin
			cond_out   = neg;
			likely_out = 1'b1;
		end
		cbdsu_pkg::CBDSU_OP_BRANCH_IF_UNEQUAL: begin
			cond_out = unequal;
		end
		cbdsu_pkg::CBDSU_OP_BRANCH_IF_UNEQUAL_LIKELY: begin
			cond_out   = unequal;
			likely_out = 1'b1;
		end
		default: begin
			is_branch_out = 1'b0;
		end
		endcase
	end

	// Offset is relative to the slot, not the branch
	assign target_out = branch_pc_in + cbdsu_pkg::CBDSU_SLOT_STEP
		+ cbdsu_sext_ofs(offset_in); // [RULE_01]
	assign link_addr_out = branch_pc_in + cbdsu_pkg::CBDSU_LINK_STEP; // [RULE_06]
endmodule

// [rtl/cbdsu_top.sv]
// Branch resolution and delay-slot sequencing unit
`timescale 1ns/1ps
module cbdsu_top (
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        issue_valid_in,
	input  wire logic [2:0]  op_in,
	input  wire logic [31:0] branch_pc_in,
	input  wire logic [15:0] offset_in,
	input  wire logic [31:0] first_source_reg_in,
	input  wire logic [31:0] second_source_reg_in,
	input  wire logic        slot_flush_in,
	output logic             link_we_out,
	output logic [4:0]       link_reg_out,
	output logic [31:0]      link_data_out,
	output logic             redirect_out,
	output logic [31:0]      redirect_pc_out,
	output logic             squash_slot_instruction_out,
	output logic             slot_active_out
);
	typedef struct packed {
		cbdsu_pkg::cbdsu_state_t state;
		logic                    cond;
		logic                    likely;
		logic [31:0]             target;
		logic                    link_we;
		logic [31:0]             link_data;
		logic                    redirect;
		logic [31:0]             redirect_pc;
		logic                    squash;
	} cbdsu_regs_t;

	cbdsu_regs_t s_reg;
	cbdsu_regs_t s_next;

	logic        ev_branch;
	logic        ev_cond;
	logic        ev_likely;
	logic        ev_link;
	logic [31:0] ev_target;
	logic [31:0] ev_link_addr;

	// Pure function of inputs, so a restart at the branch re-evaluates alike
	cbdsu_eval u_eval ( // [RULE_10]
		.op_in                (op_in),
		.branch_pc_in         (branch_pc_in),
		.offset_in            (offset_in),
		.first_source_reg_in  (first_source_reg_in),
		.second_source_reg_in (second_source_reg_in),
		.is_branch_out        (ev_branch),
		.cond_out             (ev_cond),
		.likely_out           (ev_likely),
		.link_out             (ev_link),
		.target_out           (ev_target),
		.link_addr_out        (ev_link_addr)
	);

	always_comb begin
		s_next             = s_reg;
		s_next.link_we     = 1'b0;
		s_next.redirect    = 1'b0;
		s_next.squash      = 1'b0;
		unique case (s_reg.state)
		cbdsu_pkg::CBDSU_ST_IDLE: begin
			if (issue_valid_in && ev_branch) begin
				// Capture at the branch, act in the next slot
				s_next.state  = cbdsu_pkg::CBDSU_ST_SLOT; // [RULE_08]
				s_next.cond   = ev_cond;
				s_next.likely = ev_likely;
				s_next.target = ev_target;
				// Link written regardless of outcome
				s_next.link_we   = ev_link; // [RULE_05]
				s_next.link_data = ev_link_addr; // [RULE_06]
			end
		end
		cbdsu_pkg::CBDSU_ST_SLOT: begin
			if (issue_valid_in || slot_flush_in) begin
				s_next.state = cbdsu_pkg::CBDSU_ST_IDLE;
			end
			// Flush (exception in slot) drops the redirect; core restarts at
			// the branch itself
			if (issue_valid_in && !slot_flush_in) begin
				// Redirect takes effect after the slot instruction
				s_next.redirect    = s_reg.cond; // [RULE_02]
				s_next.redirect_pc = s_reg.target; // [RULE_02]
			end
			// Squash only likely forms; plain forms run the slot.
			// A flushed slot restarts at the branch, so nothing is squashed.
			s_next.squash = issue_valid_in && !slot_flush_in
				&& s_reg.likely && !s_reg.cond; // [RULE_07] [RULE_12]
		end
		endcase
		if (sys_rst_in) begin
			s_next.state  = cbdsu_pkg::CBDSU_ST_IDLE;
			s_next.cond   = 1'b0;
			s_next.likely = 1'b0;
			s_next.target = cbdsu_pkg::CBDSU_PC_RST;
			s_next.link_we   = 1'b0;
			s_next.link_data = cbdsu_pkg::CBDSU_PC_RST;
			s_next.redirect  = 1'b0;
			s_next.redirect_pc = cbdsu_pkg::CBDSU_PC_RST;
			s_next.squash    = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		s_reg <= s_next;
	end

	assign link_we_out     = s_reg.link_we;
	assign link_reg_out    = cbdsu_pkg::CBDSU_LINK_REG;
	assign link_data_out   = s_reg.link_data;
	assign redirect_out    = s_reg.redirect;
	assign redirect_pc_out = s_reg.redirect_pc;
	assign squash_slot_instruction_out = s_reg.squash;
	assign slot_active_out = s_reg.state == cbdsu_pkg::CBDSU_ST_SLOT;

	logic [31:0] past_pc;
	always_ff @(posedge clk_in) begin
		past_pc <= branch_pc_in;
	end

	sequence seq_link_issue;
		issue_valid_in && !slot_active_out && ev_link;
	endsequence

	sequence seq_slot_taken;
		slot_active_out && issue_valid_in && !slot_flush_in && s_reg.cond;
	endsequence

	a_link_always_written: assert property ( // [RULE_05]
		@(posedge clk_in) disable iff (sys_rst_in)
		seq_link_issue |=> link_we_out)
		else $error("link write missing after linking branch");

	a_link_addr_value: assert property ( // [RULE_06]
		@(posedge clk_in) disable iff (sys_rst_in)
		link_we_out |->
			link_data_out == past_pc + cbdsu_pkg::CBDSU_LINK_STEP)
		else $error("link address not branch plus eight");

	a_target_value: assert property ( // [RULE_01]
		@(posedge clk_in) disable iff (sys_rst_in)
		ev_branch |-> ev_target == branch_pc_in
			+ cbdsu_pkg::CBDSU_SLOT_STEP
			+ {{14{offset_in[15]}}, offset_in, 2'h0})
		else $error("branch target wrong");

	a_redirect_after_slot: assert property ( // [RULE_02]
		@(posedge clk_in) disable iff (sys_rst_in)
		seq_slot_taken |=> redirect_out
			&& redirect_pc_out == $past(s_reg.target))
		else $error("taken branch not redirected after slot");

	a_no_early_redirect: assert property ( // [RULE_08]
		@(posedge clk_in) disable iff (sys_rst_in)
		(issue_valid_in && !slot_active_out && ev_branch)
			|=> !redirect_out && slot_active_out)
		else $error("redirect in branch slot itself");

	a_neg_cond_sign: assert property ( // [RULE_03]
		@(posedge clk_in) disable iff (sys_rst_in)
		(op_in inside {3'h1, 3'h2, 3'h3, 3'h4}) |->
			ev_cond == first_source_reg_in[31])
		else $error("negative test wrong");

	a_unequal_cond: assert property ( // [RULE_04]
		@(posedge clk_in) disable iff (sys_rst_in)
		(op_in inside {3'h5, 3'h6}) |->
			ev_cond == (first_source_reg_in != second_source_reg_in))
		else $error("unequal test wrong");

	a_likely_squash: assert property ( // [RULE_07]
		@(posedge clk_in) disable iff (sys_rst_in)
		(slot_active_out && issue_valid_in && !slot_flush_in
			&& s_reg.likely && !s_reg.cond)
			|=> squash_slot_instruction_out && !redirect_out)
		else $error("likely not-taken slot not squashed");

	a_plain_no_squash: assert property ( // [RULE_12]
		@(posedge clk_in) disable iff (sys_rst_in)
		(slot_active_out && !s_reg.likely) |=> !squash_slot_instruction_out)
		else $error("plain branch squashed its slot");

	a_flush_drops_slot: assert property ( // [RULE_10]
		@(posedge clk_in) disable iff (sys_rst_in)
		(slot_active_out && slot_flush_in) |=> !redirect_out
			&& !squash_slot_instruction_out && !slot_active_out)
		else $error("flushed slot still redirected or squashed");

	a_repeatable_eval: assert property ( // [RULE_10]
		@(posedge clk_in) disable iff (sys_rst_in)
		($stable(op_in) && $stable(first_source_reg_in)
			&& $stable(second_source_reg_in) && $stable(branch_pc_in)
			&& $stable(offset_in)) |-> $stable(ev_cond) && $stable(ev_target))
		else $error("evaluation not repeatable");
endmodule

// [test/cbdsu_testbench.sv]
// Self-checking bench for the branch resolution and delay-slot unit
`timescale 1ns/1ps
module testbench;
	logic        clk_in               = 1'b0;
	logic        sys_rst_in           = 1'b1;
	logic        issue_valid_in       = 1'b0;
	logic [2:0]  op_in                = 3'h0;
	logic [31:0] branch_pc_in         = 32'h0;
	logic [15:0] offset_in            = 16'h0;
	logic [31:0] first_source_reg_in  = 32'h0;
	logic [31:0] second_source_reg_in = 32'h0;
	logic        slot_flush_in        = 1'b0;
	logic        link_we_out;
	logic [4:0]  link_reg_out;
	logic [31:0] link_data_out;
	logic        redirect_out;
	logic [31:0] redirect_pc_out;
	logic        squash_slot_instruction_out;
	logic        slot_active_out;
	logic [33:0] exp_q[$];
	logic [33:0] seen;
	int          n_errors = 0;
	int          compares = 0;
	int          seed     = 32'h142D2267;

	cbdsu_top i_cbdsu_top (
		.clk_in                      (clk_in),
		.sys_rst_in                  (sys_rst_in),
		.issue_valid_in              (issue_valid_in),
		.op_in                       (op_in),
		.branch_pc_in                (branch_pc_in),
		.offset_in                   (offset_in),
		.first_source_reg_in         (first_source_reg_in),
		.second_source_reg_in        (second_source_reg_in),
		.slot_flush_in               (slot_flush_in),
		.link_we_out                 (link_we_out),
		.link_reg_out                (link_reg_out),
		.link_data_out               (link_data_out),
		.redirect_out                (redirect_out),
		.redirect_pc_out             (redirect_pc_out),
		.squash_slot_instruction_out (squash_slot_instruction_out),
		.slot_active_out             (slot_active_out)
	);

	always #12.5 clk_in = ~clk_in;

	task automatic chk(input logic [33:0] got, input logic [33:0] want);
		compares++;
		if (got !== want) begin
			n_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, got, want);
		end
	endtask

	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Record: kind 1 link, 2 redirect, 3 squash; pulses settle by negedge
	always @(negedge clk_in) begin
		if (sys_rst_in === 1'b0 && (link_we_out === 1'b1 ||
		    redirect_out === 1'b1 || squash_slot_instruction_out === 1'b1)) begin
			seen = (link_we_out === 1'b1) ? {2'h1, link_data_out} :
			       (redirect_out === 1'b1) ? {2'h2, redirect_pc_out} : {2'h3, 32'h0};
			if (link_we_out === 1'b1)
				chk({29'h0, link_reg_out}, {29'h0, cbdsu_pkg::CBDSU_LINK_REG});
			chk(seen, (exp_q.size() > 0) ? exp_q.pop_front() : 34'h0);
		end
	end

	// Sources flip during the slot: a result must depend on branch-time values
	// Tested values never come from register 31 in link forms
	task automatic branch(input logic [2:0] op, input logic [31:0] pc,
		input logic [15:0] off, input logic [31:0] a, input logic [31:0] b,
		input int stall, input logic flush);
		logic        cond;
		logic [31:0] tgt;
		cond = (op >= 3'h5) ? (a !== b) : a[31];
		tgt  = pc + cbdsu_pkg::CBDSU_SLOT_STEP + {{14{off[15]}}, off, 2'b00};
		if (op == 3'h2 || op == 3'h3)
			exp_q.push_back({2'h1, pc + cbdsu_pkg::CBDSU_LINK_STEP});
		if (!flush && cond)
			exp_q.push_back({2'h2, tgt});
		else if (!flush && (op == 3'h3 || op == 3'h4 || op == 3'h6))
			exp_q.push_back({2'h3, 32'h0});
		issue_valid_in       = 1'b1;
		op_in                = op;
		branch_pc_in         = pc;
		offset_in            = off;
		first_source_reg_in  = a;
		second_source_reg_in = b;
		@(posedge clk_in);
		#1;
		chk({33'h0, slot_active_out}, 34'h1);
		// Without a stall valid stays up into the slot
		if (stall > 0)
			issue_valid_in = 1'b0;
		first_source_reg_in  = ~a;
		second_source_reg_in = b ^ 32'h1;
		repeat (stall) begin
			@(posedge clk_in);
			#1;
		end
		issue_valid_in = 1'b1;
		op_in          = 3'h0; // Slot is never a branch
		branch_pc_in   = pc + cbdsu_pkg::CBDSU_SLOT_STEP;
		slot_flush_in  = flush;
		@(posedge clk_in);
		#1;
		chk({33'h0, slot_active_out}, 34'h0);
		// Valid stays up with a null op, so a following call need not
		// raise it again in this time step
		slot_flush_in  = 1'b0;
	endtask

	initial begin
		#(25 * 3000);
		n_errors++;
		close_out();
	end

	initial begin
		logic [31:0] a;
		repeat (20) @(posedge clk_in);
		#1;
		sys_rst_in = 1'b0;
		chk({30'h0, link_we_out, redirect_out, squash_slot_instruction_out,
		     slot_active_out}, 34'h0);
		for (int op = 1; op <= 6; op++) begin
			branch(3'(op), 32'h0000_1000, 16'h8000, 32'h8000_0000, 32'h8000_0000, 0, 1'b0);
			branch(3'(op), 32'hFFFF_FFF0, 16'h7FFF, 32'h7FFF_FFFF, 32'hFFFF_FFFF, 1, 1'b0);
			branch(3'(op), 32'h0000_2000, 16'hFFFF, 32'h0000_0000, 32'h0000_0001, 0, 1'b0);
		end
		$display("test all branch forms done");
		branch(3'h2, 32'h0000_4000, 16'h0010, 32'hFFFF_FFFF, 32'h0, 1, 1'b1);
		branch(3'h2, 32'h0000_4000, 16'h0010, 32'hFFFF_FFFF, 32'h0, 0, 1'b0);
		branch(3'h6, 32'h0000_5000, 16'h0020, 32'h1234_5678, 32'h1234_5678, 0, 1'b1);
		$display("test slot flush and restart done");
		for (int k = 0; k < 2; k++) begin
			issue_valid_in = 1'b1;
			op_in          = (k == 0) ? 3'h0 : 3'h7;
			@(posedge clk_in);
			#1;
			chk({33'h0, slot_active_out}, 34'h0);
		end
		$display("test ignored opcodes done");
		for (int k = 0; k < 40; k++) begin
			a = $random(seed);
			branch(3'($unsigned($random(seed)) % 6 + 1), $random(seed) & 32'hFFFF_FFFC,
				16'($random(seed)), a, ($random(seed) & 1) ? a : $random(seed),
				$unsigned($random(seed)) % 3, 1'b0);
		end
		$display("test random branches done");
		repeat (3) @(posedge clk_in);
		chk(34'(exp_q.size()), 34'h0);
		close_out();
	end
endmodule
